// [rtl/fcg_clock_generator.v]
// Clock generator: mode control, frequency loop, reference monitor, bus divider, registers.
// Assumes an Avalon-MM master on clk_sys and an asynchronous oscillator input pin.
// Clocks leave the block as one-cycle enable pulses on clk_sys.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "fcg_map.vh"

// How it works
// [RULE1] Reset always lands in self-clocked mode without waiting on any reference.
// [RULE2] Off mode holds the output clock still; entered on the stop request.
// [RULE3] Self-clocked mode runs the oscillator open loop at the filter setting.
// [RULE4] Engaged internal mode locks the oscillator to a multiple of internal reference.
// [RULE5] Engaged modes pass through unlocked state, then locked state on lock detect.
// [RULE6] Bypassed external mode sends the external clock straight to the output.
// [RULE7] Engaged external mode locks the oscillator to a multiple of external reference.
// [RULE8] Post-loop divider picks one of eight power-of-two divisors, 1 to 128.
// [RULE9] Loop output engages by itself once lock is acquired.
// [RULE10] Reference loss or lock loss raises a reset or an interrupt request.
// [RULE11] Status flags show lock reached and lock dropped.
// [RULE12] External reference is monitored and its validity reported.
// [RULE13] Oscillator keeps its setting through stop so relock is quick.
// [RULE14] Oscillator keeps running at current frequency if reference disappears.
// [RULE15] Sources that are not running cannot be selected; code enters engaged external from engaged internal with no valid reference.
// [RULE16] First write choosing external mode claims the input pin; the output pin is enabled only with reference select set.
// [RULE17] First write choosing internal mode leaves both oscillator pins unused.
// [RULE18] Gain select one gives high amplitude; zero gives low-power gain control.
// [RULE19] Software copies the stored trim value into the trim register itself.
// [RULE20] A separate self-clocked source drives the real-time interrupt.
// [RULE21] The roughly 8 MHz internal source serves as debug local clock.
// [RULE22] Mode field: 00 self, 01 engaged internal, 10 bypassed, 11 engaged external.
// [RULE23] After an internal first write, external mode writes are ignored until reset.
// [RULE24] Gain, range and reference select take only the first write after reset.
// [RULE25] Prescale factor is 64 in low range and 1 in high range in engaged external mode; engaged internal mode always uses 64.
module fcg_clock_generator #(
  parameter FILT_W = 12,
  parameter WIN_W = 24,
  parameter EXT_LOSS_CYC = `FCG_EXT_LOSS_CYC,
  parameter INTREF_DIV = `FCG_INTREF_DIV
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire stopReq,
  input wire oscInPin,
  output reg oscOutPin,
  output reg oscOutOe,
  output reg oscInUsed,
  output reg highGainSelect,
  output reg generatorOutputClockEn,
  output reg loopMultipliedClockEn,
  output reg externalReferenceClockEn,
  output reg debugLocalClockEn,
  output reg fixedFrequencyEnable,
  output reg rtiClockEn,
  output reg lossResetReq,
  output reg lossIrqReq
);
  localparam ST_SCM = 7'b0000001;
  localparam ST_FEI_UNL = 7'b0000010;
  localparam ST_FEI_LCK = 7'b0000100;
  localparam ST_FBE = 7'b0001000;
  localparam ST_FEE_UNL = 7'b0010000;
  localparam ST_FEE_LCK = 7'b0100000;
  localparam ST_OFF = 7'b1000000;
  localparam DBG_RELOAD = `FCG_DBG_DIV - 1;
  localparam RTI_RELOAD = `FCG_RTI_DIV - 1;
  function [WIN_W-1:0] absDiff;
    input [WIN_W-1:0] a;
    input [WIN_W-1:0] b;
    begin
      absDiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction
  reg [7:0] ctrl1_reg;
  reg [7:0] ctrl2_reg;
  reg [7:0] trim_reg;
  reg [FILT_W-1:0] filt_reg;
  reg firstDone_reg;
  reg extAllowed_reg;
  reg lockLost_reg;
  reg refLost_reg;
  reg [6:0] state_reg;
  reg [6:0] state_next;
  // Bus slave: request seen, then one cycle with waitrequest low
  wire busReq = avs_read | avs_write;
  wire busAck = busReq & ~avs_waitrequest;
  wire wrAck = avs_write & busAck & avs_byteenable[0];
  wire [1:0] wrMode = avs_writedata[`FCG_C1_MODE_HI:`FCG_C1_MODE_LO];
  reg [31:0] rdMux;
  // External pin passes three flops; a change counts when the last two agree
  reg [2:0] extSync_reg;
  reg extLevel_reg;
  wire extRise = (extSync_reg[1] == extSync_reg[2]) & extSync_reg[2] & ~extLevel_reg;
  reg [15:0] extIdle_reg;
  reg [2:0] extGood_reg;
  reg extValid_reg;
  reg [15:0] intRefCnt_reg;
  reg intRefTick_reg;
  reg [7:0] dbgCnt_reg;
  reg [7:0] rtiCnt_reg;
  wire dcoTick;
  wire extMode = state_reg[3] | state_reg[4] | state_reg[5];
  wire engaged = state_reg[1] | state_reg[2] | state_reg[4] | state_reg[5];
  wire refTick = (state_reg[4] | state_reg[5]) ? extRise : intRefTick_reg;
  wire [6:0] prescale = ((state_reg[4] | state_reg[5]) & ~ctrl1_reg[`FCG_C1_RANGE]) ?
    `FCG_P_LOW : ((state_reg[4] | state_reg[5]) ? `FCG_P_HIGH : `FCG_P_LOW); // [RULE25]
  wire [31:0] targetWide = {25'd0, prescale} *
    ({29'd0, ctrl2_reg[`FCG_C2_MULT_HI:`FCG_C2_MULT_LO]} + 32'd1) * `FCG_TARGET_UNIT;
  wire [WIN_W-1:0] target = targetWide[WIN_W-1:0];
  reg [6:0] winRef_reg;
  reg [WIN_W-1:0] winCnt_reg;
  reg [2:0] goodWin_reg;
  reg locked_reg;
  wire winEnd = refTick & (winRef_reg + 7'd1 >= prescale);
  wire [WIN_W-1:0] err = absDiff(winCnt_reg, target);
  wire refGone = (state_reg[4] | state_reg[5]) & ~extValid_reg;
  wire lockDrop = locked_reg & winEnd & (err > `FCG_UNLOCK_TOL);
  wire refDrop = extValid_reg & (extIdle_reg == EXT_LOSS_CYC[15:0] - 16'd1) & extMode;
  wire locEvent = ~ctrl1_reg[`FCG_C1_LOCDIS] & (lockDrop | refDrop);
  reg [7:0] divCnt_reg;
  wire srcTick = state_reg[3] ? extRise : dcoTick;
  wire [7:0] divMask = (8'h01 << ctrl2_reg[`FCG_C2_BDIV_HI:`FCG_C2_BDIV_LO]) - 8'h01;

  fcg_dco #(
    .WORD_W(FILT_W),
    .ACC_W(16)
  ) uDco (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(~state_reg[6]), // [RULE2] [RULE13]
    .freqWord(filt_reg),
    .tick(dcoTick)
  );

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      extSync_reg <= 3'b000;
      extLevel_reg <= 1'b0;
    end else begin
      extSync_reg <= {extSync_reg[1:0], oscInPin};
      if (extSync_reg[1] == extSync_reg[2])
        extLevel_reg <= extSync_reg[2];
    end
  end
  // Reference monitor: valid after a few edges, lost after a quiet spell
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      extIdle_reg <= 16'h0000;
      extGood_reg <= 3'h0;
      extValid_reg <= 1'b0;
    end else if (extRise) begin
      extIdle_reg <= 16'h0000;
      if (extGood_reg != `FCG_EXT_GOOD_EDGES)
        extGood_reg <= extGood_reg + 3'h1;
      else
        extValid_reg <= 1'b1; // [RULE12]
    end else if (extIdle_reg == EXT_LOSS_CYC[15:0] - 16'd1) begin
      extGood_reg <= 3'h0;
      extValid_reg <= 1'b0; // [RULE12]
    end else begin
      extIdle_reg <= extIdle_reg + 16'h0001;
    end
  end
  // Internal sources are free dividers of the system clock
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      intRefCnt_reg <= 16'h0000;
      intRefTick_reg <= 1'b0;
      dbgCnt_reg <= 8'h00;
      rtiCnt_reg <= 8'h00;
      debugLocalClockEn <= 1'b0;
      rtiClockEn <= 1'b0;
    end else begin
      intRefTick_reg <= (intRefCnt_reg == 16'h0000);
      if (intRefCnt_reg == 16'h0000)
        intRefCnt_reg <= INTREF_DIV[15:0] + {8'h00, trim_reg} - 16'h0080;
      else
        intRefCnt_reg <= intRefCnt_reg - 16'h0001;
      debugLocalClockEn <= (dbgCnt_reg == 8'h00); // [RULE21]
      dbgCnt_reg <= (dbgCnt_reg == 8'h00) ? DBG_RELOAD[7:0] : (dbgCnt_reg - 8'h01);
      rtiClockEn <= (rtiCnt_reg == 8'h00); // [RULE20]
      rtiCnt_reg <= (rtiCnt_reg == 8'h00) ? RTI_RELOAD[7:0] : (rtiCnt_reg - 8'h01);
    end
  end
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (!stopReq)
          state_next = ST_SCM;
      end
      default: begin
        if (stopReq) begin
          state_next = ST_OFF; // [RULE2]
        end else begin
          case (ctrl1_reg[`FCG_C1_MODE_HI:`FCG_C1_MODE_LO]) // [RULE22]
            `FCG_MODE_FEI: state_next = locked_reg ? ST_FEI_LCK : ST_FEI_UNL; // [RULE4] [RULE5]
            `FCG_MODE_FBE: state_next = extValid_reg ? ST_FBE : ST_SCM; // [RULE6] [RULE15]
            `FCG_MODE_FEE: begin
              if (!extValid_reg && !engaged)
                state_next = ST_SCM; // [RULE15]
              else
                state_next = locked_reg ? ST_FEE_LCK : ST_FEE_UNL; // [RULE7] [RULE5] [RULE9]
            end
            default: state_next = ST_SCM; // [RULE3]
          endcase
        end
      end
    endcase
  end
  // Frequency loop: count oscillator ticks over a window of P reference ticks
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_SCM; // [RULE1]
      winRef_reg <= 7'h00;
      winCnt_reg <= {WIN_W{1'b0}};
      goodWin_reg <= 3'h0;
      locked_reg <= 1'b0;
      filt_reg <= `FCG_FILT_RST;
    end else begin
      state_reg <= state_next;
      if (!engaged || refGone) begin
        // Filter frozen: without a reference the oscillator holds its frequency
        winRef_reg <= 7'h00;
        winCnt_reg <= {WIN_W{1'b0}}; // [RULE14]
        if (!engaged) begin
          goodWin_reg <= 3'h0;
          locked_reg <= 1'b0;
        end
        if (wrAck && avs_address == `FCG_OFS_FILT && !engaged)
          filt_reg <= avs_writedata[FILT_W-1:0]; // [RULE3]
      end else if (winEnd) begin
        winRef_reg <= 7'h00;
        winCnt_reg <= {{(WIN_W-1){1'b0}}, dcoTick};
        if (err <= `FCG_LOCK_TOL) begin
          if (goodWin_reg == `FCG_LOCK_WINDOWS - 1)
            locked_reg <= 1'b1; // [RULE5] [RULE9]
          else
            goodWin_reg <= goodWin_reg + 3'h1;
        end else begin
          goodWin_reg <= 3'h0;
          if (err > `FCG_UNLOCK_TOL)
            locked_reg <= 1'b0;
          if (winCnt_reg < target && filt_reg != {FILT_W{1'b1}})
            filt_reg <= filt_reg + 1'b1; // [RULE4] [RULE7]
          else if (winCnt_reg > target && filt_reg != {FILT_W{1'b0}})
            filt_reg <= filt_reg - 1'b1;
        end
      end else begin
        if (refTick)
          winRef_reg <= winRef_reg + 7'h01;
        if (dcoTick)
          winCnt_reg <= winCnt_reg + 1'b1;
      end
    end
  end
  // Control registers with write-once fields
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl1_reg <= `FCG_CTRL1_RST;
      ctrl2_reg <= `FCG_CTRL2_RST;
      trim_reg <= `FCG_TRIM_RST; // [RULE19]
      firstDone_reg <= 1'b0;
      extAllowed_reg <= 1'b0;
    end else if (wrAck) begin
      if (avs_address == `FCG_OFS_CTRL1) begin
        firstDone_reg <= 1'b1;
        if (!firstDone_reg) begin
          ctrl1_reg <= avs_writedata[7:0]; // [RULE24]
          extAllowed_reg <= wrMode[1]; // [RULE16] [RULE17]
        end else begin
          ctrl1_reg[`FCG_C1_OSCSTOP] <= avs_writedata[`FCG_C1_OSCSTOP];
          ctrl1_reg[`FCG_C1_LOCDIS] <= avs_writedata[`FCG_C1_LOCDIS];
          if (extAllowed_reg || !wrMode[1])
            ctrl1_reg[`FCG_C1_MODE_HI:`FCG_C1_MODE_LO] <= wrMode; // [RULE23]
        end
      end else if (avs_address == `FCG_OFS_CTRL2) begin
        ctrl2_reg <= avs_writedata[7:0];
      end else if (avs_address == `FCG_OFS_TRIM) begin
        trim_reg <= avs_writedata[7:0];
      end
    end
  end
  // Sticky loss flags; a new event wins over a write-one clear
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      lockLost_reg <= 1'b0;
      refLost_reg <= 1'b0;
      lossIrqReq <= 1'b0;
      lossResetReq <= 1'b0;
    end else begin
      if (lockDrop)
        lockLost_reg <= 1'b1; // [RULE11]
      else if (wrAck && avs_address == `FCG_OFS_STAT && avs_writedata[`FCG_ST_LOLS])
        lockLost_reg <= 1'b0;
      if (refDrop)
        refLost_reg <= 1'b1;
      else if (wrAck && avs_address == `FCG_OFS_STAT && avs_writedata[`FCG_ST_REFLS])
        refLost_reg <= 1'b0;
      lossResetReq <= locEvent & ctrl2_reg[`FCG_C2_LOSSRST]; // [RULE10]
      if (locEvent && !ctrl2_reg[`FCG_C2_LOSSRST])
        lossIrqReq <= 1'b1; // [RULE10]
      else if (!lockLost_reg && !refLost_reg)
        lossIrqReq <= 1'b0;
    end
  end
  // Clock selection, post-loop divider and pin use
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      divCnt_reg <= 8'h00;
      generatorOutputClockEn <= 1'b0;
      loopMultipliedClockEn <= 1'b0;
      externalReferenceClockEn <= 1'b0;
      fixedFrequencyEnable <= 1'b0;
      oscInUsed <= 1'b0;
      oscOutPin <= 1'b0;
      oscOutOe <= 1'b0;
      highGainSelect <= 1'b0;
    end else begin
      generatorOutputClockEn <= 1'b0;
      if (!state_reg[6] && srcTick) begin // [RULE2]
        divCnt_reg <= (divCnt_reg >= divMask) ? 8'h00 : (divCnt_reg + 8'h01);
        generatorOutputClockEn <= (divCnt_reg >= divMask); // [RULE8]
      end
      loopMultipliedClockEn <= dcoTick & ~state_reg[6];
      externalReferenceClockEn <= extRise & extValid_reg; // [RULE15]
      fixedFrequencyEnable <= extMode & extValid_reg;
      oscInUsed <= firstDone_reg & extAllowed_reg; // [RULE16] [RULE17]
      oscOutOe <= firstDone_reg & extAllowed_reg & ctrl1_reg[`FCG_C1_REFSEL]; // [RULE16]
      oscOutPin <= ~extLevel_reg;
      highGainSelect <= ctrl1_reg[`FCG_C1_GAIN]; // [RULE18]
    end
  end

  always @* begin
    rdMux = 32'h00000000;
    if (avs_address == `FCG_OFS_CTRL1)
      rdMux[7:0] = ctrl1_reg;
    else if (avs_address == `FCG_OFS_CTRL2)
      rdMux[7:0] = ctrl2_reg;
    else if (avs_address == `FCG_OFS_STAT)
      rdMux[5:0] = {extMode & extValid_reg, state_reg[6], extValid_reg, refLost_reg,
        lockLost_reg, locked_reg}; // [RULE11] [RULE12]
    else if (avs_address == `FCG_OFS_TRIM)
      rdMux[7:0] = trim_reg;
    else if (avs_address == `FCG_OFS_FILT)
      rdMux[FILT_W-1:0] = filt_reg;
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (busAck) begin
      avs_waitrequest <= 1'b1;
    end else if (busReq) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rdMux : 32'h00000000;
    end
  end
endmodule

// [rtl/fcg_map.vh]
// Register map, field positions, reset values and timing counts for the clock generator.
// Assumes a word-addressed register bus with 32-bit data; registers sit in the low bits.
`ifndef FCG_MAP_VH
`define FCG_MAP_VH

// Word indexes on the register bus
`define FCG_OFS_CTRL1 3'h0
`define FCG_OFS_CTRL2 3'h1
`define FCG_OFS_STAT 3'h2
`define FCG_OFS_TRIM 3'h3
`define FCG_OFS_FILT 3'h4

// Control register one
`define FCG_C1_GAIN 7
`define FCG_C1_RANGE 6
`define FCG_C1_REFSEL 5
`define FCG_C1_MODE_HI 4
`define FCG_C1_MODE_LO 3
`define FCG_C1_OSCSTOP 2
`define FCG_C1_LOCDIS 1

// Control register two
`define FCG_C2_LOSSRST 7
`define FCG_C2_MULT_HI 6
`define FCG_C2_MULT_LO 4
`define FCG_C2_BDIV_HI 2
`define FCG_C2_BDIV_LO 0

// Status register
`define FCG_ST_LOCK 0
`define FCG_ST_LOLS 1
`define FCG_ST_REFLS 2
`define FCG_ST_EXTOK 3
`define FCG_ST_OFF 4
`define FCG_ST_SRC 5

// Clock mode field encodings
`define FCG_MODE_SCM 2'b00
`define FCG_MODE_FEI 2'b01
`define FCG_MODE_FBE 2'b10
`define FCG_MODE_FEE 2'b11

// Reset values
`define FCG_CTRL1_RST 8'h00
`define FCG_CTRL2_RST 8'h00
`define FCG_TRIM_RST 8'h80
`define FCG_FILT_RST 12'h400

// Loop prescale factors
`define FCG_P_LOW 7'd64
`define FCG_P_HIGH 7'd1

// Timing: 250 MHz system clock, 4 ns period
`define FCG_CLK_NS 4
`define FCG_EXT_LOSS_NS 2000
`define FCG_EXT_LOSS_CYC (`FCG_EXT_LOSS_NS / `FCG_CLK_NS)
`define FCG_INTREF_DIV 1029
`define FCG_DBG_DIV 31
`define FCG_RTI_DIV 250
`define FCG_EXT_GOOD_EDGES 4
`define FCG_LOCK_WINDOWS 4
`define FCG_LOCK_TOL 4
`define FCG_UNLOCK_TOL 16
`define FCG_TARGET_UNIT 4

`endif

// [rtl/fcg_dco.v]
// Controlled oscillator modelled as a phase accumulator on the system clock.
// Assumes the frequency word is steady between loop updates.
`timescale 1ns/10ps
module fcg_dco #(
  parameter WORD_W = 12,
  parameter ACC_W = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire run,
  input wire [WORD_W-1:0] freqWord,
  output reg tick
);
  reg [ACC_W-1:0] phase_reg;
  wire [ACC_W:0] sum;

  assign sum = {1'b0, phase_reg} + {{(ACC_W+1-WORD_W){1'b0}}, freqWord};

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_reg <= {ACC_W{1'b0}};
      tick <= 1'b0;
    end else if (run) begin
      phase_reg <= sum[ACC_W-1:0];
      tick <= sum[ACC_W];
    end else begin
      // Phase is frozen so the output stands still without losing its setting
      tick <= 1'b0;
    end
  end
endmodule

// [tb/fcg_clock_generator_sva.sv]
// Port checker for the clock generator.
// Assumes binding to fcg_clock_generator on its single clk_sys domain.
`timescale 1ns/10ps
module fcg_clock_generator_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic stopReq,
  input wire logic oscOutOe,
  input wire logic oscInUsed,
  input wire logic generatorOutputClockEn,
  input wire logic loopMultipliedClockEn,
  input wire logic debugLocalClockEn,
  input wire logic fixedFrequencyEnable,
  input wire logic rtiClockEn,
  input wire logic lossResetReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop");
  chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 3'h4
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_start_self: assert property ($rose(rst_n) |-> ##[1:200] generatorOutputClockEn)
    else $error("no output clock after reset");
  chk_off_static: assert property (stopReq [*3]
    |-> !generatorOutputClockEn && !loopMultipliedClockEn)
    else $error("clock moved in off mode");
  chk_pins_claimed: assert property (oscOutOe |-> oscInUsed)
    else $error("pin driven while unclaimed");
  chk_claim_kept: assert property (oscInUsed |=> oscInUsed)
    else $error("pin claim dropped");
  chk_ffe_source: assert property (fixedFrequencyEnable |-> oscInUsed)
    else $error("external source used while unclaimed");
  chk_debug_period: assert property (debugLocalClockEn |-> ##31 debugLocalClockEn)
    else $error("debug clock period wrong");
  chk_rti_period: assert property (rtiClockEn |-> ##250 rtiClockEn)
    else $error("interrupt clock period wrong");
  chk_loss_pulse: assert property (lossResetReq |=> !lossResetReq)
    else $error("loss reset longer than a cycle");
endmodule

bind fcg_clock_generator fcg_clock_generator_sva u_sva (.*);

// [tb/fcg_ext_clock_source.sv]
// External square-wave source on the oscillator input pin.
// Assumes the bench gates it; when halted it holds its level like a stopped source.
`timescale 1ns/10ps
module fcg_ext_clock_source #(
  parameter real HALF_NS = 20.7
) (
  input wire logic run,
  output logic pin
);
  // Half period off the 2 ns grid keeps 19 of every 20 edges away from clk_sys edges; every 20th lands on one
  initial begin
    pin = 1'b0;
    forever begin
      #HALF_NS;
      if (run) pin = ~pin;
    end
  end
endmodule

// [tb/fcg_clock_generator_tb_top.sv]
// Self-checking bench for the clock generator.
// Assumes the Avalon-MM register map of fcg_map.vh and a 250 MHz clk_sys.
`timescale 1ns/10ps
`include "fcg_map.vh"
module fcg_clock_generator_tb_top;
  logic clk_sys, rst_n, avs_read, avs_write, stopReq, extRun;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, rdData;
  logic [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, oscInPin, oscOutPin, oscOutOe, oscInUsed, highGainSelect;
  wire genEn, loopEn, extEn, dbgEn, ffe, rtiEn, lossRst, lossIrq;
  int errors, n_tests, lc, oc, ec;

  // Trim 0x5a left by t_reset makes the internal reference period 64 cycles, so 0xfff locks
  fcg_clock_generator #(.EXT_LOSS_CYC(40), .INTREF_DIV(101)) DUT (.clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stopReq(stopReq),
    .oscInPin(oscInPin), .oscOutPin(oscOutPin), .oscOutOe(oscOutOe), .oscInUsed(oscInUsed),
    .highGainSelect(highGainSelect), .generatorOutputClockEn(genEn),
    .loopMultipliedClockEn(loopEn), .externalReferenceClockEn(extEn),
    .debugLocalClockEn(dbgEn), .fixedFrequencyEnable(ffe), .rtiClockEn(rtiEn),
    .lossResetReq(lossRst), .lossIrqReq(lossIrq));
  fcg_ext_clock_source u_src (.run(extRun), .pin(oscInPin));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task end_sim;
    $display("errors=%0d tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task near(input int got, input int exp, input int tol, input string m);
    n_tests++;
    if (got > exp + tol || got < exp - tol) begin
      errors++;
      $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases it
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0);
    chk(k, 2, "bus answer time");
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task count(input int n);
    lc = 0;
    oc = 0;
    ec = 0;
    repeat (n) begin
      @(posedge clk_sys);
      lc += (loopEn === 1'b1);
      oc += (genEn === 1'b1);
      ec += (extEn === 1'b1);
    end
  endtask

  task do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task t_reset;
    bus(0, `FCG_OFS_STAT, 0);
    chk(rdData, 0, "status");
    bus(0, `FCG_OFS_CTRL1, 0);
    chk(rdData, `FCG_CTRL1_RST, "ctrl1");
    bus(0, `FCG_OFS_FILT, 0);
    chk(rdData, `FCG_FILT_RST, "filter");
    bus(0, `FCG_OFS_TRIM, 0);
    chk(rdData, `FCG_TRIM_RST, "trim");
    bus(1, `FCG_OFS_TRIM, 32'h5a);
    bus(0, `FCG_OFS_TRIM, 0);
    chk(rdData, 32'h5a, "trim copy");
    for (int a = 5; a < 8; a++) begin
      bus(1, a[2:0], 32'hffffffff);
      bus(0, a[2:0], 0);
      chk(rdData, 0, "unmapped");
    end
  endtask

  task t_divider;
    bus(1, `FCG_OFS_FILT, 32'hfff);
    count(2048);
    near(lc, (2048 * 4095) >> 16, 2, "free run rate");
    for (int d = 0; d < 8; d++) begin
      bus(1, `FCG_OFS_CTRL2, d);
      count(2048);
      near(oc, lc >> d, 1, "bus divider");
    end
    bus(1, `FCG_OFS_CTRL2, 0);
  endtask

  task t_off;
    stopReq <= 1'b1;
    repeat (3) @(posedge clk_sys);
    count(200);
    near(lc + oc, 0, 0, "off clocks");
    bus(0, `FCG_OFS_STAT, 0);
    chk(rdData[`FCG_ST_OFF], 1, "off flag");
    stopReq <= 1'b0;
    count(512);
    near(lc, (512 * 4095) >> 16, 2, "rate after stop");
  endtask

  task t_internal;
    int k;
    bus(1, `FCG_OFS_CTRL1, 32'h88);
    // Register and pin outputs follow the write by two edges
    repeat (2) @(posedge clk_sys);
    chk(highGainSelect, 1, "gain");
    chk(oscInUsed, 0, "pins free");
    bus(0, `FCG_OFS_STAT, 0);
    chk(rdData[`FCG_ST_LOCK], 0, "unlocked first");
    bus(1, `FCG_OFS_CTRL1, 32'h18);
    bus(0, `FCG_OFS_CTRL1, 0);
    chk(rdData[7:3], 5'b10001, "write once");
    k = 0;
    do begin
      bus(0, `FCG_OFS_STAT, 0);
      k++;
    end while (rdData[`FCG_ST_LOCK] !== 1'b1 && k < 9000);
    chk(rdData[1:0], 2'b01, "lock");
  endtask

  task t_external;
    logic seen;
    do_reset;
    bus(1, `FCG_OFS_CTRL1, 32'h10);
    repeat (20) @(posedge clk_sys);
    chk(oscInUsed, 1, "pins claimed");
    chk(oscOutOe, 0, "no crystal drive");
    chk(oscOutPin, 1, "idle drive level");
    chk(ffe, 0, "dead source");
    bus(0, `FCG_OFS_STAT, 0);
    chk(rdData[5:3], 0, "dead source status");
    extRun <= 1'b1;
    repeat (100) @(posedge clk_sys);
    bus(0, `FCG_OFS_STAT, 0);
    chk(rdData[5:3], 3'b101, "bypass status");
    chk(ffe, 1, "fixed enable");
    count(1050);
    near(oc, 101, 3, "bypass rate");
    near(ec, 101, 3, "ext ref rate");
    extRun <= 1'b0;
    repeat (60) @(posedge clk_sys);
    bus(0, `FCG_OFS_STAT, 0);
    chk(rdData[3:2], 2'b01, "ref lost");
    chk(lossIrq, 1, "loss irq");
    bus(1, `FCG_OFS_STAT, 32'h6);
    repeat (2) @(posedge clk_sys);
    chk(lossIrq, 0, "irq cleared");
    bus(1, `FCG_OFS_CTRL2, 32'h80);
    extRun <= 1'b1;
    repeat (100) @(posedge clk_sys);
    extRun <= 1'b0;
    seen = 1'b0;
    repeat (80) begin
      @(posedge clk_sys);
      seen = seen | (lossRst === 1'b1);
    end
    chk(seen, 1, "loss reset");
  endtask

  initial begin
    #400000;
    errors++;
    $display("BAD %0t timeout", $time);
    end_sim;
  end

  initial begin
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    stopReq = 1'b0;
    extRun = 1'b0;
    do_reset;
    t_reset;
    t_divider;
    t_off;
    t_internal;
    t_external;
    end_sim;
  end
endmodule
